//--- pkg/scrb_pkg.sv
/*
 * Constants of the system control register bank: register indices, field
 * positions, reset values, fixed codes and watchdog timing.
 * Assumes a 32-bit APB master; each register index occupies one word,
 * so the byte address is four times the index.
 */
package scrb_pkg;

    // ************************************************************
    // Register indices (byte address = 4 * index)
    // ************************************************************
    localparam logic [15:0] IDX_SYSTEM_STATUS    = 16'h8200;
    localparam logic [15:0] IDX_SYSTEM_CONTROL   = 16'h8201;
    localparam logic [15:0] IDX_WATCHDOG_CONFIG  = 16'h8203;
    localparam logic [15:0] IDX_OPTION_CODE      = 16'h8204;
    localparam logic [15:0] IDX_SETUP_CONTROL    = 16'h8205;
    localparam logic [15:0] IDX_LOGIC_REVISION   = 16'h8206;
    localparam logic [15:0] IDX_TWO_WIRE         = 16'h820b;
    localparam logic [15:0] IDX_CONFIG_SWITCHES  = 16'h820c;
    localparam logic [15:0] IDX_DIGITAL_INPUTS   = 16'h8210;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int LOCK_BIT        = 7;
    localparam int TIMEOUT_MSB     = 2;
    localparam int EXPIRED_BIT     = 4;
    localparam int KICK_BIT        = 6;
    localparam int READY_BIT       = 7;
    localparam int RUN_BIT         = 6;
    localparam int USB_ALL_BIT     = 1;
    localparam int USB_LOW_BIT     = 0;
    localparam int CLOCK_LATCH_BIT = 7;
    localparam int DATA_LATCH_BIT  = 6;
    localparam int CLOCK_PIN_BIT   = 5;
    localparam int DATA_PIN_BIT    = 4;

    // ************************************************************
    // Reset values and fixed codes
    // ************************************************************
    localparam logic [7:0] WATCHDOG_CONFIG_RESET = 8'h80;
    localparam logic [7:0] SETUP_CONTROL_RESET   = 8'h00;
    localparam logic [7:0] HW_RESET_COMMAND      = 8'ha5;
    localparam logic [7:0] OPTION_CODE_DEFAULT   = 8'h3c;  // Arbitrary value
    localparam logic [7:0] REVISION_CODE_DEFAULT = 8'h01;  // Arbitrary value
    localparam logic [7:0] STATUS_OTHER_BITS     = 8'hef;
    localparam logic [7:0] CONTROL_OTHER_BITS    = 8'h8d;
    localparam logic [3:0] TWO_WIRE_LOW_NIBBLE   = 4'hf;

    // ************************************************************
    // Watchdog timing: one tick every TICK_MS milliseconds
    // ************************************************************
    localparam int          CLOCK_HZ      = 25_000_000;
    localparam int          TICK_MS       = 100;
    localparam int          TICK_CYCLES   = CLOCK_HZ / 1000 * TICK_MS;
    localparam int          TICK_WIDTH    = 12;
    // Timeouts 1.6, 5, 9, 17, 33, 65, 129, 257 s expressed in ticks
    localparam logic [11:0] TIMEOUT_TICKS [8] = '{12'h010, 12'h032, 12'h05a, 12'h0aa,
                                                  12'h14a, 12'h28a, 12'h50a, 12'ha0a};

endpackage : scrb_pkg

//--- rtl/scrb_top.sv
/*
 * System control register bank on APB: watchdog configuration and counter,
 * board reset request, setup bits (ready LED, watchdog run, USB power),
 * revision and option codes, bit-banged open-collector two-wire port,
 * switch and digital input readback.
 * Assumes one 25 MHz clock and an asynchronous active-low board reset;
 * hw_reset_req drives the system reset, not rst_b, so the expired flag
 * survives a watchdog reset.
 */
// What this block does
// RL1: Timeout code 0..7 selects 1.6 s up to 257 s; code reads back.
// RL2: Top config bit locks watchdog enable; reads 1 while locked.
// RL3: A config register write clears the watchdog expired flag, unless a timeout sets it in the same cycle.
// RL4: Option register reads fixed code; writing A5h starts full hardware reset.
// RL5: Setup bit 7 drives green ready LED, readable and writable.
// RL6: Setup bit 6 starts or stops watchdog; reads 1 while running.
// RL7: Setup bit 1 switches all USB power; reads ports 2/3 state.
// RL8: Setup bit 0 reads ports 0/1 power; writes ignored.
// RL9: Revision register reads fixed code; writes do nothing.
// RL10: Clock latch bit drives open-collector line; read returns line level.
// RL11: Data latch bit drives open-collector line; read returns line level.
// RL12: Bits 5 and 4 report sampled clock and data pin levels.
// RL13: Low nibble of two-wire register reads 1; software writes 1s.
// RL14: Switch register: second switch upper nibble, first switch lower nibble.
// RL15: Digital input register upper group in bits 7 to 4, high reads 1.
// RL16: Software writes 0 to reserved bits and never writes switch register.
// RL17: Config register resets to 80h; bits 6 to 4 read 0.
// RL18: Status bit 4 reads 0 after timeout, 1 otherwise, until cleared.
// RL19: Untriggered watchdog raises hardware reset; kick by toggling control bit 6.
// RL20: Locked running watchdog ignores disable writes until next hardware reset; a config write clearing bit 7 also unlocks it here.
// RL21: Lower input group sits in bits 3 to 0, same encoding.
`timescale 1ns/1ps

module scrb_top #(
    parameter int ADDR_WIDTH  = 18,
    parameter int TICK_CYCLES = scrb_pkg::TICK_CYCLES,
    parameter int RESET_PULSE = 16,
    parameter logic [7:0] OPTION_CODE   = scrb_pkg::OPTION_CODE_DEFAULT,
    parameter logic [7:0] REVISION_CODE = scrb_pkg::REVISION_CODE_DEFAULT
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // Board outputs
    output logic                       ready_led,
    output logic                       usb_all_power_enable,
    output logic                       hw_reset_req,
    output logic                       watchdog_running,
    // Two-wire open-collector pins
    input  wire logic                  clock_line_i,
    output logic                       clock_line_o,
    output logic                       clock_line_oe_n,
    input  wire logic                  data_line_i,
    output logic                       data_line_o,
    output logic                       data_line_oe_n,
    // Switches and digital inputs
    input  wire logic [3:0]            switch_a,
    input  wire logic [3:0]            switch_b,
    input  wire logic [3:0]            input_group_lower,
    input  wire logic [3:0]            input_group_upper
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    initial begin
        if (ADDR_WIDTH < 18 || ADDR_WIDTH > 32) begin
            $error("ADDR_WIDTH must be 18 to 32");
        end
        if (TICK_CYCLES < 1 || RESET_PULSE < 1 || RESET_PULSE > 255) begin
            $error("TICK_CYCLES and RESET_PULSE out of range");
        end
    end

    // ************************************************************
    // Types and functions
    // ************************************************************
    typedef enum logic [1:0] {
        SCRB_WD_IDLE  = 2'b01,
        SCRB_WD_COUNT = 2'b10
    } scrb_wd_state_type;

    function automatic logic idx_hit(input logic [ADDR_WIDTH-1:0] addr, input logic [15:0] idx);
        idx_hit = (addr[1:0] == 2'b00) && (addr[ADDR_WIDTH-1:2] == (ADDR_WIDTH-2)'(idx));
    endfunction : idx_hit

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [17:0] pins_meta;
    logic [17:0] pins_sync;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pins_meta <= '0;
            pins_sync <= '0;
        end else begin
            pins_meta <= {clock_line_i, data_line_i, switch_b, switch_a, input_group_upper, input_group_lower};
            pins_sync <= pins_meta;
        end
    end

    logic       clock_line_level;
    logic       data_line_level;
    logic [3:0] switch_b_level;
    logic [3:0] switch_a_level;
    logic [3:0] upper_level;
    logic [3:0] lower_level;

    assign {clock_line_level, data_line_level, switch_b_level, switch_a_level,
            upper_level, lower_level} = pins_sync;

    // ************************************************************
    // APB decode
    // ************************************************************
    logic       setup_phase;
    logic       mapped;
    logic       wr_en;
    logic [7:0] wbyte;
    logic [7:0] next_rdata;

    assign setup_phase = psel && !penable && !pready;
    assign mapped = idx_hit(paddr, scrb_pkg::IDX_SYSTEM_STATUS)   || idx_hit(paddr, scrb_pkg::IDX_SYSTEM_CONTROL)
                 || idx_hit(paddr, scrb_pkg::IDX_WATCHDOG_CONFIG) || idx_hit(paddr, scrb_pkg::IDX_OPTION_CODE)
                 || idx_hit(paddr, scrb_pkg::IDX_SETUP_CONTROL)   || idx_hit(paddr, scrb_pkg::IDX_LOGIC_REVISION)
                 || idx_hit(paddr, scrb_pkg::IDX_TWO_WIRE)        || idx_hit(paddr, scrb_pkg::IDX_CONFIG_SWITCHES)
                 || idx_hit(paddr, scrb_pkg::IDX_DIGITAL_INPUTS);
    // Only the low byte lane carries register data
    assign wr_en = psel && penable && pready && pwrite && !pslverr && pstrb[0];
    assign wbyte = pwdata[7:0];

    // ************************************************************
    // Register state
    // ************************************************************
    logic       lock;
    logic [2:0] timeout_sel;
    logic       timeout_top;
    logic       run;
    logic       kick;
    logic       expired_n;
    logic       timed_out;
    logic [7:0] reset_count;

    logic wr_config;
    logic wr_option;
    logic wr_setup;
    logic wr_control;
    logic wr_two_wire;
    logic hw_reset_event;

    assign wr_config   = wr_en && idx_hit(paddr, scrb_pkg::IDX_WATCHDOG_CONFIG);
    assign wr_option   = wr_en && idx_hit(paddr, scrb_pkg::IDX_OPTION_CODE);
    assign wr_setup    = wr_en && idx_hit(paddr, scrb_pkg::IDX_SETUP_CONTROL);
    assign wr_control  = wr_en && idx_hit(paddr, scrb_pkg::IDX_SYSTEM_CONTROL);
    assign wr_two_wire = wr_en && idx_hit(paddr, scrb_pkg::IDX_TWO_WIRE);
    assign hw_reset_event = (wr_option && wbyte == scrb_pkg::HW_RESET_COMMAND) || timed_out; // RL4 RL19

    // Watchdog configuration; a generated hardware reset restores it too
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            lock        <= scrb_pkg::WATCHDOG_CONFIG_RESET[scrb_pkg::LOCK_BIT]; // RL17
            timeout_top <= 1'b0;
            timeout_sel <= '0;
        end else if (hw_reset_event) begin
            lock        <= scrb_pkg::WATCHDOG_CONFIG_RESET[scrb_pkg::LOCK_BIT];
            timeout_top <= 1'b0;
            timeout_sel <= '0;
        end else if (wr_config) begin
            lock        <= wbyte[scrb_pkg::LOCK_BIT]; // RL2
            timeout_top <= wbyte[3];
            timeout_sel <= wbyte[scrb_pkg::TIMEOUT_MSB:0]; // RL1
        end
    end

    // Setup register
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ready_led            <= scrb_pkg::SETUP_CONTROL_RESET[scrb_pkg::READY_BIT];
            run                  <= scrb_pkg::SETUP_CONTROL_RESET[scrb_pkg::RUN_BIT];
            usb_all_power_enable <= scrb_pkg::SETUP_CONTROL_RESET[scrb_pkg::USB_ALL_BIT];
        end else if (hw_reset_event) begin
            ready_led            <= scrb_pkg::SETUP_CONTROL_RESET[scrb_pkg::READY_BIT];
            run                  <= scrb_pkg::SETUP_CONTROL_RESET[scrb_pkg::RUN_BIT];
            usb_all_power_enable <= scrb_pkg::SETUP_CONTROL_RESET[scrb_pkg::USB_ALL_BIT];
        end else if (wr_setup) begin
            ready_led            <= wbyte[scrb_pkg::READY_BIT]; // RL5
            usb_all_power_enable <= wbyte[scrb_pkg::USB_ALL_BIT]; // RL7 RL8
            // Lock only blocks stopping; starting is always allowed
            if (wbyte[scrb_pkg::RUN_BIT] || !(lock && run)) begin
                run <= wbyte[scrb_pkg::RUN_BIT]; // RL6 RL20
            end
        end
    end

    assign watchdog_running = run;

    // Control register kick bit
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            kick <= scrb_pkg::CONTROL_OTHER_BITS[scrb_pkg::KICK_BIT];
        end else if (wr_control) begin
            kick <= wbyte[scrb_pkg::KICK_BIT];
        end
    end

    // Two-wire output latches; 1 releases the line
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clock_line_oe_n <= 1'b1;
            data_line_oe_n  <= 1'b1;
            clock_line_o    <= 1'b0;
            data_line_o     <= 1'b0;
        end else if (wr_two_wire) begin
            clock_line_oe_n <= wbyte[scrb_pkg::CLOCK_LATCH_BIT]; // RL10
            data_line_oe_n  <= wbyte[scrb_pkg::DATA_LATCH_BIT]; // RL11
        end
    end

    // ************************************************************
    // Watchdog counter
    // ************************************************************
    logic [31:0]                       tick_div;
    logic                              tick;
    logic [scrb_pkg::TICK_WIDTH-1:0]   tick_count;
    logic                              kick_seen;
    scrb_wd_state_type                 wd_state;

    assign tick = (tick_div == 32'(TICK_CYCLES - 1));

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tick_div <= '0;
        end else if (wd_state != SCRB_WD_COUNT || tick) begin
            tick_div <= '0;
        end else begin
            tick_div <= tick_div + 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_state   <= SCRB_WD_IDLE;
            tick_count <= '0;
            kick_seen  <= 1'b0;
            timed_out  <= 1'b0;
        end else begin
            kick_seen <= kick;
            timed_out <= 1'b0;
            case (wd_state)
                SCRB_WD_IDLE: begin
                    tick_count <= '0;
                    if (run && !hw_reset_event) begin
                        wd_state <= SCRB_WD_COUNT;
                    end
                end
                SCRB_WD_COUNT: begin
                    if (!run || hw_reset_event) begin
                        wd_state <= SCRB_WD_IDLE;
                    end else if (kick != kick_seen) begin
                        tick_count <= '0; // RL19
                    end else if (tick) begin
                        if (tick_count + 12'h1 >= scrb_pkg::TIMEOUT_TICKS[timeout_sel]) begin
                            timed_out <= 1'b1; // RL19
                            wd_state  <= SCRB_WD_IDLE;
                        end else begin
                            tick_count <= tick_count + 12'h1;
                        end
                    end
                end
                default: begin
                    wd_state <= SCRB_WD_IDLE;
                end
            endcase
        end
    end

    // Expired flag: a timeout wins over a clear in the same cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            expired_n <= 1'b1;
        end else if (timed_out) begin
            expired_n <= 1'b0; // RL18
        end else if (wr_config || (wr_option && wbyte == scrb_pkg::HW_RESET_COMMAND)) begin
            expired_n <= 1'b1; // RL3 RL4
        end
    end

    // Reset request pulse stretched to RESET_PULSE cycles
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reset_count  <= '0;
            hw_reset_req <= 1'b0;
        end else if (hw_reset_event) begin
            reset_count  <= 8'(RESET_PULSE - 1);
            hw_reset_req <= 1'b1;
        end else if (reset_count != 8'h0) begin
            reset_count  <= reset_count - 8'h1;
        end else begin
            hw_reset_req <= 1'b0;
        end
    end

    // ************************************************************
    // Read multiplexer and APB answer
    // ************************************************************
    always_comb begin
        next_rdata = 8'h00;
        if (idx_hit(paddr, scrb_pkg::IDX_SYSTEM_STATUS)) begin
            next_rdata = scrb_pkg::STATUS_OTHER_BITS;
            next_rdata[scrb_pkg::EXPIRED_BIT] = expired_n; // RL18
        end else if (idx_hit(paddr, scrb_pkg::IDX_SYSTEM_CONTROL)) begin
            next_rdata = scrb_pkg::CONTROL_OTHER_BITS;
            next_rdata[scrb_pkg::KICK_BIT] = kick;
        end else if (idx_hit(paddr, scrb_pkg::IDX_WATCHDOG_CONFIG)) begin
            next_rdata = {lock, 3'b000, timeout_top, timeout_sel}; // RL1 RL2 RL17
        end else if (idx_hit(paddr, scrb_pkg::IDX_OPTION_CODE)) begin
            next_rdata = OPTION_CODE; // RL4
        end else if (idx_hit(paddr, scrb_pkg::IDX_SETUP_CONTROL)) begin
            next_rdata = {ready_led, run, 4'h0, usb_all_power_enable, usb_all_power_enable}; // RL5 RL6 RL7 RL8
        end else if (idx_hit(paddr, scrb_pkg::IDX_LOGIC_REVISION)) begin
            next_rdata = REVISION_CODE; // RL9
        end else if (idx_hit(paddr, scrb_pkg::IDX_TWO_WIRE)) begin
            next_rdata = {clock_line_level, data_line_level, clock_line_level, data_line_level,
                          scrb_pkg::TWO_WIRE_LOW_NIBBLE}; // RL10 RL11 RL12 RL13
        end else if (idx_hit(paddr, scrb_pkg::IDX_CONFIG_SWITCHES)) begin
            next_rdata = {switch_b_level, switch_a_level}; // RL14
        end else if (idx_hit(paddr, scrb_pkg::IDX_DIGITAL_INPUTS)) begin
            next_rdata = {upper_level, lower_level}; // RL15 RL21
        end
    end

    // No wait state: answer is prepared in the setup cycle
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (setup_phase) begin
            pready  <= 1'b1;
            pslverr <= !mapped;
            prdata  <= (!pwrite && mapped) ? {24'h0, next_rdata} : 32'h0;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule : scrb_top

//--- tb/scrb_assertions.sv
/* Checker for scrb_top: APB answer timing and register side effects.
   Assumes it is bound to scrb_top and sees only that module's ports. */
`timescale 1ns/1ps
module scrb_checker #(
    parameter int         ADDR_WIDTH    = 18,
    parameter logic [7:0] REVISION_CODE = 8'h01
) (
    // Clock, reset and APB
    input wire logic                  clk,
    input wire logic                  rst_b,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0]           pwdata,
    input wire logic [3:0]            pstrb,
    input wire logic [31:0]           prdata,
    input wire logic                  pready,
    // Board and two-wire outputs
    input wire logic                  ready_led,
    input wire logic                  usb_all_power_enable,
    input wire logic                  hw_reset_req,
    input wire logic                  watchdog_running,
    input wire logic                  clock_line_o,
    input wire logic                  clock_line_oe_n,
    input wire logic                  data_line_o,
    input wire logic                  data_line_oe_n
);
    // ************************************************************
    // Decoded accesses
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire logic acc = psel && penable && pready;
    wire logic wr  = acc && pwrite && pstrb[0];
    wire logic w_set = wr && paddr == ADDR_WIDTH'({scrb_pkg::IDX_SETUP_CONTROL, 2'b00});
    wire logic w_tw  = wr && paddr == ADDR_WIDTH'({scrb_pkg::IDX_TWO_WIRE, 2'b00});
    wire logic w_opt = wr && paddr == ADDR_WIDTH'({scrb_pkg::IDX_OPTION_CODE, 2'b00});
    wire logic r_rev = acc && !pwrite && paddr == ADDR_WIDTH'({scrb_pkg::IDX_LOGIC_REVISION, 2'b00});

    property p_answer; psel && !penable |=> pready ##1 !pready; endproperty
    a_answer: assert property (p_answer) else $error("answer not one cycle after setup");
    property p_led; w_set |=> ready_led == $past(pwdata[7]); endproperty
    a_led: assert property (p_led) else $error("ready led not written");
    property p_usb; w_set |=> usb_all_power_enable == $past(pwdata[1]); endproperty
    a_usb: assert property (p_usb) else $error("usb power not written");
    property p_run; w_set && pwdata[6] |=> watchdog_running; endproperty
    a_run: assert property (p_run) else $error("watchdog not started");
    property p_hwr; w_opt && pwdata[7:0] == 8'ha5 |-> ##[1:2] hw_reset_req [*8]; endproperty
    a_hwr: assert property (p_hwr) else $error("no reset pulse after command");
    property p_clk_oe; w_tw |=> clock_line_oe_n == $past(pwdata[7]); endproperty
    a_clk_oe: assert property (p_clk_oe) else $error("clock latch not written");
    property p_dat_oe; w_tw |=> data_line_oe_n == $past(pwdata[6]); endproperty
    a_dat_oe: assert property (p_dat_oe) else $error("data latch not written");
    property p_oc; !clock_line_o && !data_line_o; endproperty
    a_oc: assert property (p_oc) else $error("line driven high");
    property p_rev; r_rev |-> prdata == {24'h000000, REVISION_CODE}; endproperty
    a_rev: assert property (p_rev) else $error("wrong revision code");
    c_set: cover property (w_set && pwdata[6]);
    c_opt: cover property (w_opt && pwdata[7:0] == 8'ha5);
    c_hwr: cover property ($rose(hw_reset_req));
endmodule : scrb_checker

bind scrb_top scrb_checker #(.ADDR_WIDTH(ADDR_WIDTH), .REVISION_CODE(REVISION_CODE)) i_chk (
    .clk, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .ready_led,
    .usb_all_power_enable, .hw_reset_req, .watchdog_running, .clock_line_o, .clock_line_oe_n,
    .data_line_o, .data_line_oe_n);

//--- tb/tb_top.sv
/* Self-checking bench for scrb_top over APB.
   Assumes the two-wire lines have pull-ups and the tick is shortened. */
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin bad_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
    localparam logic [7:0]  OPT = 8'h69;  // Arbitrary value
    localparam logic [7:0]  REV = 8'h5a;  // Arbitrary value
    localparam logic [15:0] CFG = scrb_pkg::IDX_WATCHDOG_CONFIG;
    localparam logic [15:0] SET = scrb_pkg::IDX_SETUP_CONTROL;
    localparam logic [15:0] TW  = scrb_pkg::IDX_TWO_WIRE;
    logic        clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, pull_data = 0, rst_seen = 0;
    logic [17:0] paddr = '0;
    logic [3:0]  strb = 4'hf;
    logic [31:0] pwdata = '0, prdata;
    logic        pready, pslverr, led, usb, hwr, run, cli, clo, cloe, dli, dlo, dloe;
    int          checked = 0, bad_count = 0;
    always #20 clk = ~clk;
    // Pull-ups on both lines; the bench may hold data low
    assign cli = cloe ? 1'b1 : clo;
    assign dli = (dloe ? 1'b1 : dlo) & ~pull_data;
    always @(posedge clk) if (hwr === 1'b1) rst_seen <= 1'b1;
    scrb_top #(.TICK_CYCLES(10), .OPTION_CODE(OPT), .REVISION_CODE(REV)) i_dut (
        .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .ready_led(led), .usb_all_power_enable(usb), .hw_reset_req(hwr), .watchdog_running(run),
        .clock_line_i(cli), .clock_line_o(clo), .clock_line_oe_n(cloe), .data_line_i(dli),
        .data_line_o(dlo), .data_line_oe_n(dloe), .switch_a(4'h5), .switch_b(4'hc),
        .input_group_lower(4'h3), .input_group_upper(4'ha));
    // ************************************************************
    // Bus tasks
    // ************************************************************
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : stop_test
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d,
                       output logic [7:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= {idx, 2'b00}; pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
        r = prdata[7:0];
        e = pslverr;
        if (n >= 20) begin bad_count++; stop_test(); end
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [15:0] idx, input logic [7:0] d);
        logic [7:0] r; logic e;
        apb(1'b1, idx, d, r, e);
    endtask : wr
    task automatic rdc(input logic [15:0] idx, input logic [7:0] x);
        logic [7:0] r; logic e;
        apb(1'b0, idx, 8'h00, r, e);
        `CHK(r, x)
    endtask : rdc
    task automatic wait_hwr(input logic lvl, output int n);
        n = 0;
        while (hwr !== lvl && n < 400) begin @(negedge clk); n++; end
        if (n >= 400) begin bad_count++; stop_test(); end
    endtask : wait_hwr
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        rdc(CFG, 8'h80);
        rdc(SET, 8'h00);
        rdc(scrb_pkg::IDX_LOGIC_REVISION, REV);
        rdc(scrb_pkg::IDX_OPTION_CODE, OPT);
        rdc(TW, 8'hff);
        rdc(scrb_pkg::IDX_CONFIG_SWITCHES, 8'hc5);
        rdc(scrb_pkg::IDX_DIGITAL_INPUTS, 8'ha3);
        $display("done: reset values");
    endtask : t_reset
    task automatic t_regs();
        logic [7:0] r; logic e;
        for (int i = 0; i < 8; i++) begin
            wr(CFG, 8'(i));
            rdc(CFG, 8'(i));
        end
        wr(CFG, 8'h0f);
        rdc(CFG, 8'h0f);
        // Low byte lane disabled: write must not land
        strb <= 4'he;
        wr(SET, 8'h80);
        strb <= 4'hf;
        rdc(SET, 8'h00);
        wr(SET, 8'h82);
        @(negedge clk);
        `CHK(led, 1'b1)
        `CHK(usb, 1'b1)
        rdc(SET, 8'h83);
        wr(SET, 8'h01);
        rdc(SET, 8'h00);
        wr(scrb_pkg::IDX_LOGIC_REVISION, 8'hff);
        rdc(scrb_pkg::IDX_LOGIC_REVISION, REV);
        apb(1'b0, 16'h8207, 8'h00, r, e);
        `CHK({e, r}, 9'h100)
        $display("done: register access");
    endtask : t_regs
    task automatic t_two_wire();
        wr(TW, 8'h4f);
        repeat (3) @(posedge clk);
        rdc(TW, 8'h5f);
        pull_data <= 1'b1;
        wr(TW, 8'hcf);
        repeat (3) @(posedge clk);
        rdc(TW, 8'haf);
        pull_data <= 1'b0;
        $display("done: two-wire port");
    endtask : t_two_wire
    task automatic t_watchdog();
        int n;
        wr(CFG, 8'h00);
        wr(SET, 8'h40);
        for (int k = 1; k < 4; k++) begin
            repeat (90) @(posedge clk);
            wr(scrb_pkg::IDX_SYSTEM_CONTROL, {1'b0, k[0], 6'h00});
        end
        `CHK(rst_seen, 1'b0)
        wait_hwr(1'b1, n);
        `CHK(n > 140 && n < 175, 1'b1)
        wait_hwr(1'b0, n);
        rdc(scrb_pkg::IDX_SYSTEM_STATUS, 8'hef);
        wr(CFG, 8'h03);
        rdc(scrb_pkg::IDX_SYSTEM_STATUS, 8'hff);
        $display("done: watchdog timeout");
    endtask : t_watchdog
    task automatic t_lock();
        int n;
        wr(CFG, 8'h83);
        rdc(CFG, 8'h83);
        wr(SET, 8'h40);
        wr(SET, 8'h00);
        @(negedge clk);
        `CHK(run, 1'b1)
        rdc(SET, 8'h40);
        wr(scrb_pkg::IDX_OPTION_CODE, 8'ha5);
        wait_hwr(1'b1, n);
        wait_hwr(1'b0, n);
        `CHK(n, 16)
        `CHK(run, 1'b0)
        rdc(CFG, 8'h80);
        $display("done: lock and board reset");
    endtask : t_lock
    initial begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_reset();
        t_regs();
        t_two_wire();
        t_watchdog();
        t_lock();
        stop_test();
    end
endmodule : tb_top
